// file: hdl/down_timer_pkg.sv
// constants shared by the down timer: register map, control fields, reset values
// assumes a classic wishbone slave with 32-bit data, registers one per word
// How it works
// - sixteen-bit down counter behind eight-bit prescaler, single/continuous
// - clock source core/4 or input pin; oscillator-derived clock is synchronised but not selectable
// - underflow at zero is the end of count
// - interrupt request shares an external interrupt channel
// - run bit set starts counting, clear stops
// - restart resumes held count unless new constant
// - counter bytes apply at end, prescaler immediately
// - unprogrammed registers count from all ones
// - single mode stops, reloads, clears run bit
// - continuous mode reloads and keeps counting
// - mode bit writable anytime, together with run
// - input disabled: core/4 clock, pin ignored
// - event mode counts input pin falling edges
// - gated mode counts core/4 while pin high
// - triggerable mode needs run bit and falling edge
// - retriggerable falling edge restarts from constants while running
// - output disabled holds output pin high
// - square wave toggles output each end
// - pwm copies lower output bit at end
// - prescaler divides by value plus one
// - route select one passes external pin instead
// - counter reads live, prescaler reads programmed value
package down_timer_pkg;
  // register byte addresses
  localparam logic [3:0] counter_high_byte_addr = 4'h0;
  localparam logic [3:0] counter_low_byte_addr = 4'h4;
  localparam logic [3:0] prescaler_value_addr = 4'h8;
  localparam logic [3:0] timer_control_addr = 4'hC;
  // timer_control field positions
  localparam int run_control_pos = 7;
  localparam int single_mode_pos = 6;
  localparam int input_mode_upper_pos = 5;
  localparam int input_mode_lower_pos = 4;
  localparam int input_enable_pos = 3;
  localparam int route_select_pos = 2;
  localparam int output_mode_upper_pos = 1;
  localparam int output_mode_lower_pos = 0;
  // reset values
  localparam logic [7:0] counter_byte_reset = 8'hFF;
  localparam logic [7:0] prescaler_reset = 8'hFF;
  localparam logic [7:0] control_reset = 8'h14;
  // core clock division for the internal count clock
  localparam logic [1:0] core_div_last = 2'h3;
  // input modes (upper, lower)
  typedef enum logic [1:0] {
    in_event = 2'b00,
    in_gated = 2'b01,
    in_trigger = 2'b10,
    in_retrigger = 2'b11
  } in_mode_t;
endpackage

// file: hdl/pin_sync.sv
// two-stage synchroniser for the timer pin inputs, with falling edge detect
// assumes the inputs are asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic pin,
  output logic level,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // two flops, then a third for edge detection
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign fall = prev_q & ~sync_q;
endmodule
`default_nettype wire

// file: hdl/down_timer.sv
// standard down timer: 16-bit counter, 8-bit prescaler, input and output modes
// assumes a classic wishbone master on mclk; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module down_timer
  import down_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer_input_pin,
  input wire logic oscillator_derived_clock,
  input wire logic ext_irq_pin,
  output logic timer_output_pin,
  output logic irq_channel
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [7:0] const_high_q;
  logic [7:0] const_low_q;
  logic [7:0] prescaler_value_q;
  logic run_q;
  logic single_q;
  logic input_mode_upper_bit_q;
  logic input_mode_lower_bit_q;
  logic input_section_enable_q;
  logic interrupt_route_select_q;
  logic output_mode_upper_bit_q;
  logic output_mode_lower_bit_q;
  logic [15:0] count_q;
  logic [7:0] presc_cnt_q;
  logic new_const_q;
  logic armed_q;
  logic [1:0] div_q;
  logic out_q;
  logic irq_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic pin_level;
  logic pin_fall;
  logic osc_level;
  logic osc_prev_q;
  logic osc_tick;
  logic core_tick;
  logic wr;
  logic rd_strobe;
  logic ctl_wr;
  logic const_wr;
  logic start_wr;
  logic [7:0] ctl_byte;
  logic [7:0] ctl_now;
  in_mode_t in_mode;
  logic src_tick;
  logic enable_count;
  logic count_tick;
  logic eoc;
  logic retrig;
  logic ext_meta_q;
  logic ext_sync_q;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // the input pin idles high, so its synchroniser resets high and no
  // false falling edge follows reset
  pin_sync u_in_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin(timer_input_pin),
    .level(pin_level),
    .fall(pin_fall)
  );

  pin_sync u_osc_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin(oscillator_derived_clock),
    .level(osc_level),
    .fall()
  );

  // rising edge of the synchronised oscillator-derived clock
  // no control bit selects this source yet, so the tick is kept
  // ready but does not reach the prescaler
  // its flop resets low against a high synchroniser: the first tick is a false one
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_level;
    end
  end
  assign osc_tick = osc_level & ~osc_prev_q;

  // external interrupt pin: two flops, reset low so no request follows reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_irq_pin;
      ext_sync_q <= ext_meta_q;
    end
  end

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // writes land at the edge where ack is seen high, so the master and
  // the registers agree on one edge; reads are captured a cycle earlier
  // and stand on the data lines through the ack cycle
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
  assign rd_strobe = wb_cyc_i & wb_stb_i & ~ack_q;
  assign ctl_wr = wr & (wb_adr_i == timer_control_addr);
  assign const_wr = wr & ((wb_adr_i == counter_high_byte_addr) | (wb_adr_i == counter_low_byte_addr));
  assign ctl_byte = wb_dat_i[7:0];
  assign start_wr = ctl_wr & ctl_byte[run_control_pos] & ~run_q;
  assign ctl_now = {run_q, single_q, input_mode_upper_bit_q, input_mode_lower_bit_q,
                    input_section_enable_q, interrupt_route_select_q,
                    output_mode_upper_bit_q, output_mode_lower_bit_q};

  // single-wait-state ack, dropped the cycle after
  // a request is answered one cycle after it is first seen
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end
  assign wb_ack_o = ack_q;

  // read mux, registered; unmapped reads return zero
  // the prescaler reads back what was written, never its running count
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0;
    end else if (rd_strobe) begin
      case (wb_adr_i)
        counter_high_byte_addr: rdata_q <= {24'h0, count_q[15:8]};
        counter_low_byte_addr: rdata_q <= {24'h0, count_q[7:0]};
        prescaler_value_addr: rdata_q <= {24'h0, prescaler_value_q};
        timer_control_addr: rdata_q <= {24'h0, ctl_now};
        default: rdata_q <= 32'h0;
      endcase
    end
  end
  assign wb_dat_o = rdata_q;

  // ------------------------------------------------------------
  // constant and prescaler registers
  // ------------------------------------------------------------
  // all ones after reset
  // a constant written while running waits for the next end of count;
  // software that starts without programming these counts the longest period
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      const_high_q <= counter_byte_reset;
      const_low_q <= counter_byte_reset;
      prescaler_value_q <= prescaler_reset;
    end else if (wr) begin
      if (wb_adr_i == counter_high_byte_addr) const_high_q <= wb_dat_i[7:0];
      if (wb_adr_i == counter_low_byte_addr) const_low_q <= wb_dat_i[7:0];
      if (wb_adr_i == prescaler_value_addr) prescaler_value_q <= wb_dat_i[7:0];
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  // mode bits written any time; hardware clears run in single mode
  // a software run write wins over the single-mode clear in one cycle,
  // so a restart issued at the end of count is not lost
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      {run_q, single_q, input_mode_upper_bit_q, input_mode_lower_bit_q,
       input_section_enable_q, interrupt_route_select_q,
       output_mode_upper_bit_q, output_mode_lower_bit_q} <= control_reset;
    end else begin
      if (ctl_wr) begin
        single_q <= ctl_byte[single_mode_pos];
        input_mode_upper_bit_q <= ctl_byte[input_mode_upper_pos];
        input_mode_lower_bit_q <= ctl_byte[input_mode_lower_pos];
        input_section_enable_q <= ctl_byte[input_enable_pos];
        interrupt_route_select_q <= ctl_byte[route_select_pos];
        output_mode_upper_bit_q <= ctl_byte[output_mode_upper_pos];
        output_mode_lower_bit_q <= ctl_byte[output_mode_lower_pos];
      end
      if (ctl_wr) begin
        run_q <= ctl_byte[run_control_pos];
      end else if (eoc & single_q) begin
        run_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // count clock selection
  // ------------------------------------------------------------
  // core clock divided by four as a one-cycle enable
  // free running, so the phase of ticks does not follow the run bit;
  // the first step after a start may come one to four cycles later
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  assign core_tick = (div_q == core_div_last);

  assign in_mode = in_mode_t'({input_mode_upper_bit_q, input_mode_lower_bit_q});

  // source of prescaler ticks
  // disabled input section: core ticks only, mode bits ignored
  // gated and triggerable modes hold the prescaler rather than the source
  always_comb begin
    src_tick = core_tick;
    enable_count = run_q;
    if (input_section_enable_q) begin
      case (in_mode)
        in_event: src_tick = pin_fall;
        in_gated: enable_count = run_q & pin_level;
        in_trigger: enable_count = run_q & armed_q;
        in_retrigger: src_tick = core_tick;
        default: src_tick = core_tick;
      endcase
    end else begin
      src_tick = core_tick;
    end
  end

  // triggerable mode waits for a falling edge after the run bit is set
  // a low run bit drops the arm, so a stale edge cannot start a later run;
  // the arm stays set while running, so later edges change nothing
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
    end else if (~run_q) begin
      armed_q <= 1'b0;
    end else if (pin_fall) begin
      armed_q <= 1'b1;
    end
  end

  // retrigger restarts from the constants only while running; a falling
  // edge while stopped is ignored
  assign retrig = input_section_enable_q & (in_mode == in_retrigger) & run_q & pin_fall;

  // ------------------------------------------------------------
  // prescaler and down counter
  // ------------------------------------------------------------
  // a counter step needs a source tick with the prescaler at zero
  assign count_tick = enable_count & src_tick & (presc_cnt_q == 8'h0);
  // end of count is a step taken at zero; a retrigger in the same cycle
  // restarts the count instead, so it raises no request and no pin action
  assign eoc = count_tick & (count_q == 16'h0) & ~retrig;

  // remembers a constant written while stopped
  // cleared by the restart that consumes it; writes while running
  // leave it alone, they reach the counter at the end of count
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      new_const_q <= 1'b0;
    end else if (const_wr & ~run_q) begin
      new_const_q <= 1'b1;
    end else if (start_wr) begin
      new_const_q <= 1'b0;
    end
  end

  // prescaler counts source ticks down from the programmed value
  // a prescaler write applies at once, even mid-period
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      presc_cnt_q <= prescaler_reset;
    end else if (wr & (wb_adr_i == prescaler_value_addr)) begin
      presc_cnt_q <= wb_dat_i[7:0];
    end else if (retrig | (start_wr & new_const_q)) begin
      presc_cnt_q <= prescaler_value_q;
    end else if (enable_count & src_tick) begin
      if (presc_cnt_q == 8'h0) begin
        presc_cnt_q <= prescaler_value_q;
      end else begin
        presc_cnt_q <= presc_cnt_q - 8'h1;
      end
    end
  end

  // counter: reloads at end of count, on retrigger, or on restart with new constant
  // retrigger has priority; with no step pending the count is held,
  // which is how a stopped counter resumes where it left off
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_q <= {counter_byte_reset, counter_byte_reset};
    end else if (retrig) begin
      count_q <= {const_high_q, const_low_q};
    end else if (start_wr & new_const_q) begin
      count_q <= {const_high_q, const_low_q};
    end else if (eoc) begin
      count_q <= {const_high_q, const_low_q};
    end else if (count_tick) begin
      count_q <= count_q - 16'h1;
    end
  end

  // ------------------------------------------------------------
  // output pin and interrupt
  // ------------------------------------------------------------
  // output pin: pwm copy, square toggle or held high when disabled
  // the disabled setting forces the pin high every cycle, so leaving
  // pwm or square mode returns the pin to its idle level at once
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_q <= 1'b1;
    end else if (output_mode_upper_bit_q) begin
      if (eoc) out_q <= output_mode_lower_bit_q;
    end else if (output_mode_lower_bit_q) begin
      if (eoc) out_q <= ~out_q;
    end else begin
      out_q <= 1'b1;
    end
  end
  assign timer_output_pin = out_q;

  // shared external channel: one-cycle request per end, or the external pin
  // the external pin passes its synchroniser first, three cycles in all
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else if (interrupt_route_select_q) begin
      irq_q <= ext_sync_q;
    end else begin
      irq_q <= eoc;
    end
  end
  assign irq_channel = irq_q;
endmodule
`default_nettype wire

// file: testbench/down_timer_sva.sv
// checker: bus answer, interrupt routing and output pin of the down timer
// assumes binding into down_timer; control bits are shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
module down_timer_sva
  import down_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic ext_irq_pin,
  input wire logic timer_output_pin,
  input wire logic irq_channel
);
  logic [7:0] ctl_q;
  logic take;
  // a request is taken while ack is low
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // shadow of control; only routing and output bits are used
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctl_q <= control_reset;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == timer_control_addr) begin
      ctl_q <= wb_dat_i[7:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_ACK_PULSE: assert property (take |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
  AST_RD_UPPER: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
  AST_OUT_OFF: assert property ((ctl_q[1:0] == 2'b00) [*2] |-> timer_output_pin) else $error("pin not high");
  AST_IRQ_PULSE: assert property (irq_channel && !ctl_q[2] ##1 !ctl_q[2] |-> !irq_channel)
    else $error("irq longer than a pulse");
  AST_IRQ_ROUTE: assert property (ctl_q[2] && $past(ctl_q[2]) && !$past(sys_rst)
    |-> irq_channel == $past(ext_irq_pin, 3)) else $error("external irq not passed");
  AST_SQ_TOGGLE: assert property (ctl_q[2:0] == 3'h1 && $past(ctl_q[2:0]) == 3'h1 && irq_channel
    |-> timer_output_pin != $past(timer_output_pin)) else $error("square did not toggle");
  AST_SQ_HOLD: assert property (ctl_q[2:0] == 3'h1 && $past(ctl_q[2:0]) == 3'h1 && !irq_channel
    |-> $stable(timer_output_pin)) else $error("square moved between ends");
  AST_PWM_COPY: assert property (ctl_q[2:1] == 2'h1 && $past(ctl_q[2:1]) == 2'h1 && irq_channel
    |-> timer_output_pin == $past(ctl_q[0])) else $error("pwm bit not copied");
  // main scenarios reached
  cover property (irq_channel && ctl_q[1:0] == 2'h1);
  cover property (irq_channel && ctl_q[1]);
  cover property (irq_channel && ctl_q[2]);
endmodule
bind down_timer down_timer_sva i_sva (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_irq_pin(ext_irq_pin),
  .timer_output_pin(timer_output_pin), .irq_channel(irq_channel));
`default_nettype wire

// file: testbench/pin_source.sv
// partner: the external source that drives the timer input pin
// assumes requests come at least sixteen mclk apart
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic hold_low,
  output logic pin
);
  logic [3:0] low_q;
  // each request pulls the pin low for eight cycles, edges well spaced
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      low_q <= 4'h0;
    end else if (go) begin
      low_q <= 4'h8;
    end else if (low_q != 4'h0) begin
      low_q <= low_q - 4'h1;
    end
  end
  // idle high; a gate request holds it low
  assign pin = !hold_low && low_q == 4'h0;
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// testbench: drives the down timer over wishbone and its pins
// assumes the package, design, checker and partner are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import down_timer_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic ext_irq = 1'b0, go = 1'b0, hold_low = 1'b0, ack, tin, tout, irq, p;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, dout, v;
  int n, c, error_cnt = 0, tests_run = 0, irq_cnt = 0;
  logic [3:0] ra [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
  logic [7:0] rv [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h14, 8'h00};
  down_timer i_dut (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .timer_input_pin(tin), .oscillator_derived_clock(1'b0), .ext_irq_pin(ext_irq),
    .timer_output_pin(tout), .irq_channel(irq));
  pin_source i_src (.mclk(mclk), .sys_rst(sys_rst), .go(go), .hold_low(hold_low), .pin(tin));
  // clock and interrupt pulse counter
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle; read data taken at the ack edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, 24'h0, d};
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) error_cnt++;
    v = dout;
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic wait_irq(output int m);
    m = 0;
    do begin
      @(posedge mclk);
      m++;
    end while (irq !== 1'b1 && m < 3000);
    if (irq !== 1'b1) error_cnt++;
  endtask
  task automatic start(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] ps, input logic [7:0] ctl);
    bus(1'b1, timer_control_addr, 8'h00);
    bus(1'b1, counter_high_byte_addr, hi);
    bus(1'b1, counter_low_byte_addr, lo);
    bus(1'b1, prescaler_value_addr, ps);
    bus(1'b1, timer_control_addr, ctl);
  endtask
  // one falling edge on the input pin, then a quiet gap
  task automatic fire;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (16) @(posedge mclk);
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(1'b1, 4'h2, 8'h55);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 8'h00);
      chk(v, {24'h0, rv[i]}, "reset read");
    end
    bus(1'b1, prescaler_value_addr, 8'h01);
    bus(1'b0, prescaler_value_addr, 8'h00);
    chk(v, 32'h1, "prescaler read");
    start(8'h00, 8'h03, 8'h01, 8'h81);
    wait_irq(n);
    p = tout;
    wait_irq(n);
    chk(32'(n), 32'h20, "period");
    chk(32'(tout), 32'(!p), "square");
    repeat (10) @(posedge mclk);
    bus(1'b0, counter_low_byte_addr, 8'h00);
    chk(v, 32'h2, "live count");
    bus(1'b1, prescaler_value_addr, 8'h00);
    bus(1'b1, counter_low_byte_addr, 8'h01);
    wait_irq(n);
    wait_irq(n);
    chk(32'(n), 32'h8, "new period");
    bus(1'b1, timer_control_addr, 8'h83);
    wait_irq(n);
    wait_irq(n);
    chk(32'(tout), 32'h1, "pwm high");
    bus(1'b1, timer_control_addr, 8'h82);
    wait_irq(n);
    wait_irq(n);
    chk(32'(tout), 32'h0, "pwm low");
    start(8'h00, 8'h02, 8'h00, 8'hC0);
    wait_irq(n);
    bus(1'b0, timer_control_addr, 8'h00);
    chk(v, 32'h40, "single stop");
    chk(32'(tout), 32'h1, "output off");
    c = irq_cnt;
    repeat (40) @(posedge mclk);
    chk(32'(irq_cnt), 32'(c), "stays stopped");
    bus(1'b1, timer_control_addr, 8'hC0);
    wait_irq(n);
    bus(1'b0, timer_control_addr, 8'h00);
    chk(v, 32'h40, "restart ends again");
    start(8'h00, 8'h02, 8'h00, 8'h88);
    c = irq_cnt;
    fire();
    fire();
    chk(32'(irq_cnt), 32'(c), "two events");
    fire();
    chk(32'(irq_cnt), 32'(c + 1), "third event");
    start(8'h00, 8'h02, 8'h00, 8'hE8);
    c = irq_cnt;
    repeat (40) @(posedge mclk);
    chk(32'(irq_cnt), 32'(c), "no trigger yet");
    fire();
    repeat (20) @(posedge mclk);
    chk(32'(irq_cnt), 32'(c + 1), "triggered");
    start(8'h00, 8'h04, 8'h00, 8'hB8);
    c = irq_cnt;
    repeat (4) fire();
    chk(32'(irq_cnt), 32'(c), "retriggered");
    hold_low <= 1'b1;
    start(8'h00, 8'h10, 8'h00, 8'h98);
    repeat (40) @(posedge mclk);
    bus(1'b0, counter_low_byte_addr, 8'h00);
    chk(v, 32'h10, "gate closed");
    hold_low <= 1'b0;
    repeat (40) @(posedge mclk);
    bus(1'b0, counter_low_byte_addr, 8'h00);
    chk(32'(v < 32'h10), 32'h1, "gate open");
    bus(1'b1, timer_control_addr, 8'h04);
    ext_irq <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(32'(irq), 32'h1, "route high");
    ext_irq <= 1'b0;
    repeat (5) @(posedge mclk);
    chk(32'(irq), 32'h0, "route low");
    print_verdict();
  end
endmodule
`default_nettype wire
